// ### inc/msrm_pkg.sv
// Package holding constants, modes and carriers of the mode select and resource map block.
package msrm_pkg;

    typedef enum logic [2:0] {
        MSRM_SPECIAL_SINGLE   = 3'h0,
        MSRM_SPECIAL_NARROW   = 3'h1,
        MSRM_SPECIAL_PERIPH   = 3'h2,
        MSRM_SPECIAL_WIDE     = 3'h3,
        MSRM_NORMAL_SINGLE    = 3'h4,
        MSRM_NORMAL_NARROW    = 3'h5,
        MSRM_RESERVED         = 3'h6,
        MSRM_NORMAL_WIDE      = 3'h7
    } msrm_mode_t;

    typedef enum logic [2:0] {
        MSRM_SEL_DEBUG_ROM,
        MSRM_SEL_REGS,
        MSRM_SEL_RAM,
        MSRM_SEL_EEPROM,
        MSRM_SEL_FLASH,
        MSRM_SEL_EXTERNAL,
        MSRM_SEL_NONE
    } msrm_sel_t;

    typedef enum logic [1:0] {
        MSRM_BUS_NONE,
        MSRM_BUS_NARROW,
        MSRM_BUS_WIDE
    } msrm_bus_t;

    localparam int unsigned MSRM_MODE_COUNT   = 8;
    localparam logic [4:0] MSRM_REG_POS_RESET = 5'h00;
    localparam logic [4:0] MSRM_RAM_POS_RESET = 5'h01;
    localparam logic [3:0] MSRM_EE_POS_RESET  = 4'h0;
    localparam logic [15:0] MSRM_REG_SIZE     = 16'h0200;
    localparam logic [15:0] MSRM_RAM_SIZE     = 16'h0400;
    localparam logic [15:0] MSRM_EE_OFFSET    = 16'h0d00;
    localparam logic [15:0] MSRM_EE_TOP       = 16'h1000;
    localparam logic [7:0]  MSRM_DEBUG_PAGE   = 8'hff;
    localparam logic [7:0]  MSRM_DEBUG_CTL_LO = 8'h00;
    localparam logic [7:0]  MSRM_DEBUG_CTL_HI = 8'h06;
    localparam int unsigned MSRM_MAP_DELAY    = 2;
    localparam logic [1:0]  MSRM_PE_PULLIN    = 2'h3;

    // Mapping register write request from the core.
    typedef struct packed {
        logic       reg_we;
        logic [4:0] reg_pos;
        logic       ram_we;
        logic [4:0] ram_pos;
        logic       ee_we;
        logic [3:0] ee_pos;
    } msrm_map_wr_t;

    // Pad configuration towards ports A, B and E.
    typedef struct packed {
        msrm_bus_t  bus;
        logic       port_ab_gpio;
        logic       port_e_bus_ctl;
        logic [1:0] port_e_input_only;
        logic       port_e_pullup;
        logic       port_ab_pullup;
    } msrm_pads_t;

endpackage : msrm_pkg

// ### rtl/msrm_decode.sv
// Address decoder choosing the selected resource by fixed precedence.
`timescale 1ns/1ps
`default_nettype none
module msrm_decode
    import msrm_pkg::*;
(
    input  wire logic [15:0] addr_i,
    input  wire logic        cpu_access_i,
    input  wire logic        debug_active_i,
    input  wire logic        expanded_i,
    input  wire logic        flash_on_i,
    input  wire logic        flash_high_i,
    input  wire logic        ee_on_i,
    input  wire logic [4:0]  reg_pos_i,
    input  wire logic [4:0]  ram_pos_i,
    input  wire logic [3:0]  ee_pos_i,
    output msrm_sel_t        sel_o,
    output logic             debug_ctl_o
);

    logic in_debug;
    logic in_regs;
    logic in_ram;
    logic in_ee;
    logic in_flash;
    logic [15:0] ee_rel;

    assign ee_rel   = addr_i - {ee_pos_i, 12'h000};
    // The debug ROM covers the top page only for the core; serial debug sees user memory.
    assign in_debug = debug_active_i && cpu_access_i && (addr_i[15:8] == MSRM_DEBUG_PAGE);
    assign in_regs  = (addr_i[15:11] == reg_pos_i) && ({5'h00, addr_i[10:0]} < MSRM_REG_SIZE);
    assign in_ram   = (addr_i[15:11] == ram_pos_i) && ({5'h00, addr_i[10:0]} < MSRM_RAM_SIZE);
    assign in_ee    = ee_on_i && (addr_i[15:12] == ee_pos_i)
                      && (ee_rel >= MSRM_EE_OFFSET) && (ee_rel < MSRM_EE_TOP);
    assign in_flash = flash_on_i && (addr_i[15] == flash_high_i);
    assign debug_ctl_o = in_debug && (addr_i[7:0] >= MSRM_DEBUG_CTL_LO)
                         && (addr_i[7:0] <= MSRM_DEBUG_CTL_HI);

    always_comb begin
        if (in_debug) begin
            sel_o = MSRM_SEL_DEBUG_ROM;
        end else if (in_regs) begin
            sel_o = MSRM_SEL_REGS;
        end else if (in_ram) begin
            sel_o = MSRM_SEL_RAM;
        end else if (in_ee) begin
            sel_o = MSRM_SEL_EEPROM;
        end else if (in_flash) begin
            sel_o = MSRM_SEL_FLASH;
        end else if (expanded_i) begin
            sel_o = MSRM_SEL_EXTERNAL;
        end else begin
            sel_o = MSRM_SEL_NONE;
        end
    end

endmodule : msrm_decode
`default_nettype wire

// ### rtl/msrm_top.sv
// Operating mode latch, mode dependent pad setup, mapping registers and resource decode.
`timescale 1ns/1ps
`default_nettype none
module msrm_top
    import msrm_pkg::*;
#(
    parameter int unsigned MODES = MSRM_MODE_COUNT
)(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        background_debug_pin_i,
    input  wire logic        mode_select_b_i,
    input  wire logic        mode_select_a_i,
    input  wire logic        mode_wr_i,
    input  wire logic [1:0]  mode_wr_ba_i,
    input  wire logic        mode_wr_special_n_i,
    input  wire msrm_map_wr_t map_wr_i,
    input  wire logic        debug_enable_cmd_i,
    input  wire logic        debug_active_cmd_i,
    input  wire logic        background_entry_instr_i,
    input  wire logic        debug_exit_i,
    input  wire logic        ee_on_i,
    input  wire logic        flash_on_i,
    input  wire logic        flash_high_i,
    input  wire logic [15:0] cpu_addr_i,
    input  wire logic        cpu_access_i,
    input  wire logic [15:0] debug_addr_i,
    input  wire logic        debug_req_i,
    input  wire logic        debug_write_i,
    input  wire logic        ext_wide_i,
    output msrm_mode_t       mode_o,
    output logic             special_mode_n_bit_o,
    output logic             cpu_run_o,
    output logic             skip_reset_vector_o,
    output logic             debug_enabled_o,
    output logic             debug_active_o,
    output logic             protect_bits_o,
    output msrm_pads_t       pads_o,
    output logic             split_transfer_o,
    output logic             split_high_first_o,
    output logic [4:0]       reg_pos_o,
    output logic [4:0]       ram_pos_o,
    output logic [3:0]       ee_pos_o,
    output msrm_sel_t        cpu_sel_o,
    output logic             debug_ctl_o,
    output logic             debug_grant_o,
    output msrm_sel_t        debug_sel_o,
    output logic             debug_refused_o
);

    // Any other mode count would leave pin codes without a decode.
    if (MODES != MSRM_MODE_COUNT) begin : g_mode_count_check
        $error("msrm_top supports exactly eight modes");
    end


    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic       in_reset;
        msrm_mode_t mode;
        logic       dbg_en;
        logic       dbg_act;
        logic [4:0] reg_pos;
        logic [4:0] ram_pos;
        logic [3:0] ee_pos;
        logic       reg_done;
        logic       ram_done;
        logic       ee_done;
        logic [4:0] reg_pend;
        logic [4:0] ram_pend;
        logic [3:0] ee_pend;
        logic [2:0] pend_v;
        logic       grant;
        msrm_sel_t  dsel;
        logic       refused;
    } msrm_state_t;

    msrm_state_t state;
    msrm_state_t next_state;
    msrm_sel_t   cpu_sel;
    msrm_sel_t   dbg_sel_c;
    logic        dbg_ctl_c;
    logic        special;
    logic        expanded;
    logic        single_chip;

    function automatic logic is_special(input msrm_mode_t m);
        return (m[2] == 1'b0);
    endfunction : is_special

    function automatic logic is_expanded(input msrm_mode_t m);
        return (m[0] == 1'b1);
    endfunction : is_expanded

    function automatic logic is_single(input msrm_mode_t m);
        return (m[1:0] == 2'h0);
    endfunction : is_single

    function automatic msrm_mode_t decode_pins(input logic [2:0] p);
        msrm_mode_t m;
        m = msrm_mode_t'(p);
        if (m == MSRM_RESERVED) begin
            m = MSRM_SPECIAL_PERIPH;
        end
        return m;
    endfunction : decode_pins

    assign special     = is_special(state.mode);
    assign expanded    = is_expanded(state.mode);
    assign single_chip = is_single(state.mode);

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_state          = state;
        next_state.in_reset = 1'b0;
        next_state.grant    = 1'b0;
        next_state.refused  = 1'b0;
        next_state.pend_v   = 3'h0;
        // Pins sampled during every reset cycle; the last sample stands at the release.
        if (rst_i) begin
            next_state.in_reset = 1'b1;
            next_state.mode = decode_pins({background_debug_pin_i, mode_select_b_i,
                                           mode_select_a_i});
        end
        if (state.in_reset) begin
            // Special single-chip comes up with debug enabled and active.
            next_state.dbg_en  = (state.mode == MSRM_SPECIAL_SINGLE);
            next_state.dbg_act = (state.mode == MSRM_SPECIAL_SINGLE);
        end else if (!rst_i) begin
            // Mode bits: peripheral and reserved never reachable by a write.
            if (mode_wr_i && state.mode != MSRM_SPECIAL_PERIPH) begin
                if (special && decode_pins({mode_wr_special_n_i, mode_wr_ba_i})
                        != MSRM_SPECIAL_PERIPH) begin
                    next_state.mode = msrm_mode_t'({mode_wr_special_n_i, mode_wr_ba_i});
                end
            end
            if (debug_enable_cmd_i && state.mode != MSRM_SPECIAL_PERIPH) begin
                next_state.dbg_en = 1'b1;
            end
            if (state.dbg_en && (debug_active_cmd_i || background_entry_instr_i)) begin
                next_state.dbg_act = 1'b1;
            end else if (debug_exit_i) begin
                next_state.dbg_act = 1'b0;
            end
            // Writes are held one cycle, then applied: visible on the second cycle.
            if (map_wr_i.reg_we && (special || !state.reg_done)) begin
                next_state.reg_pend  = map_wr_i.reg_pos;
                next_state.pend_v[0] = 1'b1;
                next_state.reg_done  = 1'b1;
            end
            if (map_wr_i.ram_we && (special || !state.ram_done)) begin
                next_state.ram_pend  = map_wr_i.ram_pos;
                next_state.pend_v[1] = 1'b1;
                next_state.ram_done  = 1'b1;
            end
            if (map_wr_i.ee_we && (special || !state.ee_done)) begin
                next_state.ee_pend   = map_wr_i.ee_pos;
                next_state.pend_v[2] = 1'b1;
                next_state.ee_done   = 1'b1;
            end
            if (state.pend_v[0]) begin
                next_state.reg_pos = state.reg_pend;
            end
            if (state.pend_v[1]) begin
                next_state.ram_pos = state.ram_pend;
            end
            if (state.pend_v[2]) begin
                next_state.ee_pos = state.ee_pend;
            end
            // Debug memory access is served only in a cycle the core leaves idle.
            if (debug_req_i) begin
                if (!cpu_access_i && !(debug_write_i && (dbg_sel_c == MSRM_SEL_EEPROM
                        || dbg_sel_c == MSRM_SEL_FLASH))) begin
                    next_state.grant = 1'b1;
                    next_state.dsel  = dbg_sel_c;
                end else begin
                    next_state.refused = debug_write_i && !cpu_access_i;
                end
            end
        end
        if (rst_i) begin
            next_state.dbg_en   = 1'b0;
            next_state.dbg_act  = 1'b0;
            next_state.reg_pos  = MSRM_REG_POS_RESET;
            next_state.ram_pos  = MSRM_RAM_POS_RESET;
            next_state.ee_pos   = MSRM_EE_POS_RESET;
            next_state.reg_done = 1'b0;
            next_state.ram_done = 1'b0;
            next_state.ee_done  = 1'b0;
            next_state.pend_v   = 3'h0;
            next_state.dsel     = MSRM_SEL_NONE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////////

    msrm_decode u_cpu_dec (
        .addr_i         (cpu_addr_i),
        .cpu_access_i   (1'b1),
        .debug_active_i (state.dbg_act),
        .expanded_i     (expanded),
        .flash_on_i     (flash_on_i),
        .flash_high_i   (flash_high_i),
        .ee_on_i        (ee_on_i || single_chip),
        .reg_pos_i      (state.reg_pos),
        .ram_pos_i      (state.ram_pos),
        .ee_pos_i       (state.ee_pos),
        .sel_o          (cpu_sel),
        .debug_ctl_o    (dbg_ctl_c)
    );

    // Serial debug reaches user memory under the top page.
    msrm_decode u_dbg_dec (
        .addr_i         (debug_addr_i),
        .cpu_access_i   (1'b0),
        .debug_active_i (state.dbg_act),
        .expanded_i     (expanded),
        .flash_on_i     (flash_on_i),
        .flash_high_i   (flash_high_i),
        .ee_on_i        (ee_on_i || single_chip),
        .reg_pos_i      (state.reg_pos),
        .ram_pos_i      (state.ram_pos),
        .ee_pos_i       (state.ee_pos),
        .sel_o          (dbg_sel_c),
        .debug_ctl_o    ()
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        pads_o = '0;
        case (state.mode)
            MSRM_NORMAL_WIDE, MSRM_SPECIAL_WIDE, MSRM_SPECIAL_PERIPH: begin
                pads_o.bus = MSRM_BUS_WIDE;
            end
            MSRM_NORMAL_NARROW, MSRM_SPECIAL_NARROW: begin
                pads_o.bus = MSRM_BUS_NARROW;
            end
            default: begin
                pads_o.bus          = MSRM_BUS_NONE;
                pads_o.port_ab_gpio = 1'b1;
            end
        endcase
        pads_o.port_e_bus_ctl    = expanded && (special || state.mode == MSRM_NORMAL_WIDE
                                   || state.mode == MSRM_NORMAL_NARROW);
        pads_o.port_e_input_only = MSRM_PE_PULLIN;
        pads_o.port_e_pullup     = 1'b1;
        pads_o.port_ab_pullup    = 1'b0;
    end

    assign mode_o               = state.mode;
    assign special_mode_n_bit_o = state.mode[2];
    assign cpu_run_o            = !state.in_reset && (state.mode != MSRM_SPECIAL_PERIPH);
    assign skip_reset_vector_o  = (state.mode == MSRM_SPECIAL_SINGLE);
    assign debug_enabled_o      = state.dbg_en;
    assign debug_active_o       = state.dbg_act;
    assign protect_bits_o       = !special;
    // External 16-bit data in special narrow goes as two byte cycles, high byte first.
    assign split_transfer_o     = (state.mode == MSRM_SPECIAL_NARROW) && ext_wide_i
                                  && (cpu_sel == MSRM_SEL_EXTERNAL);
    assign split_high_first_o   = split_transfer_o;
    assign reg_pos_o            = state.reg_pos;
    assign ram_pos_o            = state.ram_pos;
    assign ee_pos_o             = state.ee_pos;
    assign cpu_sel_o            = cpu_sel;
    assign debug_ctl_o          = dbg_ctl_c;
    assign debug_grant_o        = state.grant;
    assign debug_sel_o          = state.dsel;
    assign debug_refused_o      = state.refused;

endmodule : msrm_top
`default_nettype wire

// ### sim/msrm_top_props.sv
// Concurrent checks on the ports of the mode select and resource map block.
`timescale 1ns/1ps
`default_nettype none
module msrm_top_props
    import msrm_pkg::*;
(
    input wire logic         ref_clk_i,
    input wire logic         rst_i,
    input wire logic         background_debug_pin_i,
    input wire logic         mode_select_b_i,
    input wire logic         mode_select_a_i,
    input wire msrm_map_wr_t map_wr_i,
    input wire logic [15:0]  cpu_addr_i,
    input wire logic         cpu_access_i,
    input wire logic         debug_req_i,
    input wire logic         debug_write_i,
    input wire logic         ext_wide_i,
    input wire msrm_mode_t   mode_o,
    input wire logic         cpu_run_o,
    input wire logic         skip_reset_vector_o,
    input wire logic         debug_enabled_o,
    input wire logic         debug_active_o,
    input wire logic         protect_bits_o,
    input wire msrm_pads_t   pads_o,
    input wire logic         split_transfer_o,
    input wire logic         split_high_first_o,
    input wire logic [4:0]   reg_pos_o,
    input wire msrm_sel_t    cpu_sel_o,
    input wire logic         debug_ctl_o,
    input wire logic         debug_grant_o
);
    logic [2:0] pins;
    assign pins = {background_debug_pin_i, mode_select_b_i, mode_select_a_i};
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    AST_MODE_LATCH: assert property ($fell(rst_i) |->
        mode_o == (($past(pins) == 3'h6) ? 3'h2 : $past(pins))) else $error("mode not latched");
    AST_SSC_DEBUG: assert property ($fell(rst_i) && mode_o == MSRM_SPECIAL_SINGLE |=>
        debug_active_o && skip_reset_vector_o) else $error("special single-chip debug");
    AST_CPU_STOP: assert property (mode_o == MSRM_SPECIAL_PERIPH |-> !cpu_run_o)
        else $error("core runs in peripheral mode");
    AST_PROTECT: assert property (protect_bits_o == mode_o[2]) else $error("protection");
    AST_WIDE: assert property (mode_o[1:0] == 2'h3 |-> pads_o.bus == MSRM_BUS_WIDE)
        else $error("wide bus");
    AST_NARROW: assert property (mode_o[1:0] == 2'h1 |-> pads_o.bus == MSRM_BUS_NARROW)
        else $error("narrow bus");
    AST_SINGLE: assert property (mode_o == MSRM_NORMAL_SINGLE |->
        pads_o.bus == MSRM_BUS_NONE && pads_o.port_ab_gpio && pads_o.port_e_pullup
        && pads_o.port_e_input_only == MSRM_PE_PULLIN && !pads_o.port_ab_pullup)
        else $error("single-chip pads");
    AST_BUS_CTL: assert property (mode_o == MSRM_SPECIAL_WIDE |-> pads_o.port_e_bus_ctl)
        else $error("bus control pins");
    AST_SPLIT: assert property (mode_o == MSRM_SPECIAL_NARROW && ext_wide_i
        && cpu_sel_o == MSRM_SEL_EXTERNAL |-> split_transfer_o && split_high_first_o)
        else $error("split transfer");
    AST_PERIPH_RESET_ONLY: assert property (!$past(rst_i) |->
        (mode_o == MSRM_SPECIAL_PERIPH) == ($past(mode_o) == MSRM_SPECIAL_PERIPH))
        else $error("peripheral mode changed");
    AST_DEBUG_EN: assert property ($rose(debug_active_o) && mode_o != MSRM_SPECIAL_SINGLE
        |-> debug_enabled_o) else $error("debug active without enable");
    AST_DEBUG_ROM: assert property (debug_active_o && cpu_access_i
        && cpu_addr_i[15:8] == MSRM_DEBUG_PAGE |-> cpu_sel_o == MSRM_SEL_DEBUG_ROM
        && debug_ctl_o == (cpu_addr_i[7:0] <= MSRM_DEBUG_CTL_HI)) else $error("debug page");
    AST_MAP_DELAY: assert property (map_wr_i.reg_we && !protect_bits_o && !$past(rst_i)
        |-> ##2 reg_pos_o == $past(map_wr_i.reg_pos, 2)) else $error("map write");
    AST_GRANT: assert property (debug_req_i && !cpu_access_i && !debug_write_i
        && !$past(rst_i) |=> debug_grant_o) else $error("debug grant");
endmodule : msrm_top_props
bind msrm_top msrm_top_props u_props (.ref_clk_i, .rst_i, .background_debug_pin_i,
    .mode_select_b_i, .mode_select_a_i, .map_wr_i, .cpu_addr_i, .cpu_access_i, .debug_req_i,
    .debug_write_i, .ext_wide_i, .mode_o, .cpu_run_o, .skip_reset_vector_o, .debug_enabled_o,
    .debug_active_o, .protect_bits_o, .pads_o, .split_transfer_o, .split_high_first_o,
    .reg_pos_o, .cpu_sel_o, .debug_ctl_o, .debug_grant_o);
`default_nettype wire

// ### sim/msrm_strap_host.sv
// Board side model: mode straps and the debug pod request line.
`timescale 1ns/1ps
`default_nettype none
module msrm_strap_host (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] want_i,
    input  wire logic       periph_i,
    input  wire logic       dbg_go_i,
    output logic [2:0]      pins_o,
    output logic            debug_req_o
);
    initial pins_o = 3'h4;
    // Once reset is over the strap hold has run out, so the pins wander every cycle.
    always @(negedge ref_clk_i) begin
        if (rst_i) begin
            pins_o <= want_i;
        end else begin
            pins_o <= ~pins_o;
        end
    end
    // The pod keeps off the bus while an external master owns the peripherals.
    assign debug_req_o = dbg_go_i && !periph_i;
endmodule : msrm_strap_host
`default_nettype wire

// ### sim/msrm_top_bench.sv
// Self-checking bench for the mode select and resource map block.
`timescale 1ns/1ps
`default_nettype none
module msrm_top_bench;
    import msrm_pkg::*;
    logic         ref_clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic [2:0]   want = 3'h4;
    logic [2:0]   em = 3'h4;
    logic [2:0]   pins;
    logic [2:0]   mode_new = 3'h0;
    logic [4:0]   rp = 5'h00;
    logic         dbg_go = 1'b0;
    logic         mode_wr_i = 1'b0;
    msrm_map_wr_t map_wr_i = '0;
    logic         debug_enable_cmd_i = 1'b0, debug_active_cmd_i = 1'b0;
    logic         background_entry_instr_i = 1'b0, debug_exit_i = 1'b0;
    logic         ee_on_i = 1'b0, flash_on_i = 1'b0, flash_high_i = 1'b0;
    logic         cpu_access_i = 1'b1, debug_write_i = 1'b0, ext_wide_i = 1'b0;
    logic [15:0]  cpu_addr_i = 16'h0000, debug_addr_i = 16'h0000;
    logic         debug_req_i;
    msrm_mode_t   mode_o;
    msrm_pads_t   pads_o;
    msrm_sel_t    cpu_sel_o, debug_sel_o;
    logic [4:0]   reg_pos_o, ram_pos_o;
    logic [3:0]   ee_pos_o;
    logic         special_mode_n_bit_o, cpu_run_o, skip_reset_vector_o, debug_enabled_o;
    logic         debug_active_o, protect_bits_o, split_transfer_o, split_high_first_o;
    logic         debug_ctl_o, debug_grant_o, debug_refused_o;
    int           err_count = 0;
    int           checks = 0;

    always #2 ref_clk_i = ~ref_clk_i;

    msrm_top DUT (.ref_clk_i, .rst_i, .background_debug_pin_i(pins[2]),
        .mode_select_b_i(pins[1]), .mode_select_a_i(pins[0]), .mode_wr_i,
        .mode_wr_ba_i(mode_new[1:0]), .mode_wr_special_n_i(mode_new[2]), .map_wr_i,
        .debug_enable_cmd_i, .debug_active_cmd_i, .background_entry_instr_i, .debug_exit_i,
        .ee_on_i, .flash_on_i, .flash_high_i, .cpu_addr_i, .cpu_access_i, .debug_addr_i,
        .debug_req_i, .debug_write_i, .ext_wide_i, .mode_o, .special_mode_n_bit_o, .cpu_run_o,
        .skip_reset_vector_o, .debug_enabled_o, .debug_active_o, .protect_bits_o, .pads_o,
        .split_transfer_o, .split_high_first_o, .reg_pos_o, .ram_pos_o, .ee_pos_o, .cpu_sel_o,
        .debug_ctl_o, .debug_grant_o, .debug_sel_o, .debug_refused_o);
    msrm_strap_host u_host (.ref_clk_i, .rst_i, .want_i(want), .periph_i(em == 3'h2),
        .dbg_go_i(dbg_go), .pins_o(pins), .debug_req_o(debug_req_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic cyc(int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : cyc

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse

    task automatic close_out();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // Expected owner of a core address; the RAM and EEPROM stay at their reset places.
    function automatic msrm_sel_t exp_sel(logic [15:0] a, logic dbg);
        if (dbg && a[15:8] == MSRM_DEBUG_PAGE) return MSRM_SEL_DEBUG_ROM;
        if (a[15:11] == rp && a[10:9] == 2'h0) return MSRM_SEL_REGS;
        if (a[15:11] == MSRM_RAM_POS_RESET && !a[10]) return MSRM_SEL_RAM;
        if (ee_on_i && a[15:12] == MSRM_EE_POS_RESET && a[11:0] >= 12'hd00) return MSRM_SEL_EEPROM;
        if (flash_on_i && a[15] == flash_high_i) return MSRM_SEL_FLASH;
        return em[0] ? MSRM_SEL_EXTERNAL : MSRM_SEL_NONE;
    endfunction : exp_sel

    task automatic do_reset(logic [2:0] code);
        want = code;
        em = (code == 3'h6) ? 3'h2 : code;
        rp = MSRM_REG_POS_RESET;
        rst_i = 1'b1;
        cyc(10);
        rst_i = 1'b0;
        cyc(2);
        chk("mode", mode_o, em);
        chk("special_mode_n_bit", special_mode_n_bit_o, em[2]);
        chk("cpu_run", cpu_run_o, em != 3'h2);
        chk("skip_vec", skip_reset_vector_o, em == 3'h0);
        chk("dbg_act", debug_active_o, em == 3'h0);
        chk("protect", protect_bits_o, em[2]);
        chk("pos", {reg_pos_o, ram_pos_o, ee_pos_o}, {2'h0, rp, 5'h01, 4'h0});
        if (em != 3'h2) chk("bus", pads_o.bus,
            !em[0] ? MSRM_BUS_NONE : em[1] ? MSRM_BUS_WIDE : MSRM_BUS_NARROW);
    endtask : do_reset

    task automatic mapw(logic [4:0] r, logic acc);
        map_wr_i.reg_we = 1'b1;
        map_wr_i.reg_pos = r;
        cyc(1);
        map_wr_i.reg_we = 1'b0;
        chk("reg_pos_early", reg_pos_o, rp);
        if (acc) rp = r;
        cyc(1);
        chk("reg_pos", reg_pos_o, rp);
        cyc(1);
        chk("reg_pos_hold", reg_pos_o, rp);
    endtask : mapw

    task automatic mwr(logic [2:0] v, logic [2:0] e);
        mode_new = v;
        mode_wr_i = 1'b1;
        cyc(1);
        mode_wr_i = 1'b0;
        chk("mode_wr", mode_o, e);
        em = e;
        cyc(1);
    endtask : mwr

    task automatic rand_decode(int n, logic dbg);
        repeat (n) begin
            case ($urandom_range(2))
                0: cpu_addr_i = 16'($urandom_range(16'h1fff));
                1: cpu_addr_i = {MSRM_DEBUG_PAGE, 8'($urandom_range(8'h0f))};
                default: cpu_addr_i = 16'($urandom);
            endcase
            {ee_on_i, flash_on_i, flash_high_i} = 3'($urandom);
            #1;
            chk("cpu_sel", cpu_sel_o, exp_sel(cpu_addr_i, dbg));
            chk("dbg_ctl", debug_ctl_o, dbg && cpu_addr_i[15:8] == 8'hff
                && cpu_addr_i[7:0] <= 8'h06);
            cyc(1);
        end
    endtask : rand_decode
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hf242));
        for (int c = 0; c < MSRM_MODE_COUNT; c++) begin
            do_reset(3'(c));
        end
        do_reset(3'h3);
        mapw(5'h07, 1'b1);
        mapw(5'h09, 1'b1);
        mwr(3'h2, 3'h3);
        mwr(3'h1, 3'h1);
        {ee_on_i, flash_on_i, ext_wide_i} = 3'h1;
        cpu_addr_i = 16'h4000;
        #1;
        chk("split", {split_transfer_o, split_high_first_o}, 2'h3);
        ext_wide_i = 1'b0;
        cyc(1);
        chk("split_byte", split_transfer_o, 1'b0);
        do_reset(3'h2);
        mwr(3'h3, 3'h2);
        do_reset(3'h7);
        mwr(3'h3, 3'h7);
        rand_decode(40, 1'b0);
        mapw(5'h03, 1'b1);
        mapw(5'h05, 1'b0);
        rand_decode(40, 1'b0);
        pulse(debug_active_cmd_i);
        cyc(1);
        chk("dbg_no_en", debug_active_o, 1'b0);
        pulse(debug_enable_cmd_i);
        pulse(debug_active_cmd_i);
        cyc(1);
        chk("dbg_on", debug_active_o, 1'b1);
        rand_decode(40, 1'b1);
        cpu_access_i = 1'b0;
        debug_addr_i = 16'h0800;
        dbg_go = 1'b1;
        cyc(1);
        dbg_go = 1'b0;
        chk("grant", {debug_grant_o, debug_sel_o}, {1'b1, MSRM_SEL_RAM});
        cyc(1);
        chk("grant_end", debug_grant_o, 1'b0);
        {debug_write_i, ee_on_i, debug_addr_i, dbg_go} = {2'h3, 16'h0d10, 1'b1};
        cyc(1);
        dbg_go = 1'b0;
        chk("refused", {debug_refused_o, debug_grant_o}, 2'h2);
        pulse(debug_exit_i);
        cyc(1);
        chk("dbg_exit", debug_active_o, 1'b0);
        pulse(background_entry_instr_i);
        cyc(1);
        chk("dbg_instr", debug_active_o, 1'b1);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_count++;
        close_out();
    end
endmodule : msrm_top_bench
`default_nettype wire
